//--- rtl/isa_transition_state_guard.sv
// guards stack, load-table and deferred-fault state across isa switches
`timescale 1ns/10ps
`include "isa_guard_consts.svh"
module isa_transition_state_guard
  import isa_guard_pkg::*;
(
  input  wire logic        sys_clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic        legacy_entry_branch_i,
  input  wire logic        legacy_exit_jump_i,
  input  wire logic        interruption_i,
  input  wire logic        register_stack_engine_ctrl_en_i,
  input  wire logic        stacked_valid_set_i,
  input  wire logic        clean_inc_i,
  input  wire logic        advanced_load_table_insert_i,
  input  wire logic        marker_present_i,
  input  wire logic [1:0]  legacy_op_i,
  input  wire logic [81:0] fp_src_i,
  input  wire logic        fp_src_from_mem_i,
  output logic             legacy_mode_o,
  output logic             register_stack_engine_en_o,
  output logic             stacked_valid_o,
  output logic [6:0]       clean_count_o,
  output logic             advanced_load_table_valid_o,
  output logic             deferred_fault_marker_abort_o,
  output logic             legacy_fp_error_o,
  output logic             deferred_fault_fp_value_prop_o,
  output logic [81:0]      fp_result_o,
  output logic [63:0]      vec_data_o
);
  isa_mode_t   mode_q,  mode_d;
  logic        sen_q,   sen_d;
  logic        sval_q,  sval_d;
  logic [6:0]  clean_q, clean_d;
  logic        tbl_q,   tbl_d;
  logic        abort_q, abort_d;
  logic        fperr_q, fperr_d;
  logic        prop_q,  prop_d;
  logic [81:0] fpres_q, fpres_d;
  logic [63:0] vec_q,   vec_d;
  logic        enter,   leave;
  logic        fv_src;

  fp_operand_if op ();

  fp_operand_filter u_filter
  (
    .op (op)
  );

  assign op.raw_reg = fp_src_i;
  assign op.op_kind = legacy_op_i;

  ////////////////////////////////////////////////////////////////////////////
  // isa mode and transition side effects
  always_comb
  begin
    enter   = (mode_q == ISA_NATIVE) && legacy_entry_branch_i;
    leave   = (mode_q == ISA_LEGACY) && (legacy_exit_jump_i || interruption_i);
    mode_d  = mode_q;
    sval_d  = sval_q;
    clean_d = clean_q;
    tbl_d   = tbl_q;
    if (enter)
    begin
      mode_d = ISA_LEGACY;
      tbl_d  = 1'b0;
    end
    else if (leave)
    begin
      mode_d  = ISA_NATIVE;
      sval_d  = 1'b0;
      clean_d = `CLEAN_CNT_RST;
    end
    else if (mode_q == ISA_NATIVE)
    begin
      if (stacked_valid_set_i)
      begin
        sval_d = 1'b1;
      end
      if (clean_inc_i && (clean_q != `CLEAN_CNT_MAX))
      begin
        clean_d = clean_q + 7'h01;
      end
      if (advanced_load_table_insert_i)
      begin
        tbl_d = 1'b1;
      end
    end
    sen_d = register_stack_engine_ctrl_en_i && (mode_d == ISA_NATIVE);
  end

  ////////////////////////////////////////////////////////////////////////////
  // legacy operand handling
  always_comb
  begin
    fv_src     = op.fault_val && !fp_src_from_mem_i;
    abort_d    = 1'b0;
    fperr_d    = 1'b0;
    prop_d     = 1'b0;
    fpres_d    = fpres_q;
    vec_d      = vec_q;
    if ((mode_q == ISA_LEGACY) && !leave)
    begin
      unique case (legacy_op_t'(legacy_op_i))
        OP_NONE:
        begin
        end
        OP_FP:
        begin
          if (marker_present_i)
          begin
            abort_d = 1'b1;
          end
          else if (fv_src)
          begin
            fperr_d = 1'b1;
            fpres_d = op.filtered;
          end
          else
          begin
            fpres_d = fp_src_i;
          end
        end
        OP_VEC, OP_INT:
        begin
          if (marker_present_i)
          begin
            abort_d = 1'b1;
          end
          else
          begin
            vec_d = op.mant_data;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge sys_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      mode_q  <= ISA_NATIVE;
      sen_q   <= 1'b0;
      sval_q  <= 1'b0;
      clean_q <= `CLEAN_CNT_RST;
      tbl_q   <= 1'b0;
      abort_q <= 1'b0;
      fperr_q <= 1'b0;
      prop_q  <= 1'b0;
      fpres_q <= 82'h0;
      vec_q   <= 64'h0;
    end
    else
    begin
      mode_q  <= mode_d;
      sen_q   <= sen_d;
      sval_q  <= sval_d;
      clean_q <= clean_d;
      tbl_q   <= tbl_d;
      abort_q <= abort_d;
      fperr_q <= fperr_d;
      prop_q  <= prop_d;
      fpres_q <= fpres_d;
      vec_q   <= vec_d;
    end
  end

  assign legacy_mode_o                 = (mode_q == ISA_LEGACY);
  assign register_stack_engine_en_o     = sen_q;
  assign stacked_valid_o                = sval_q;
  assign clean_count_o                  = clean_q;
  assign advanced_load_table_valid_o    = tbl_q;
  assign deferred_fault_marker_abort_o  = abort_q;
  assign legacy_fp_error_o              = fperr_q;
  assign deferred_fault_fp_value_prop_o = prop_q;
  assign fp_result_o                   = fpres_q;
  assign vec_data_o                    = vec_q;
endmodule

//--- common/isa_guard_consts.svh
// constants for the instruction-set transition guard
`ifndef ISA_GUARD_CONSTS_SVH
`define ISA_GUARD_CONSTS_SVH
`define FP_REG_W        82
`define FP_MANT_W       64
`define FP_EXP_LSB      64
`define FP_EXP_MSB      80
`define FP_SIGN_BIT     81
`define FAULT_VAL_EXP   17'h1FFFE
`define FAULT_VAL_SIGN  1'h0
`define FAULT_VAL_MANT  64'h0000000000000000
`define SNAN_EXP        17'h1FFFF
`define SNAN_MANT       64'h8000000000000001
`define CLEAN_CNT_W     7
`define CLEAN_CNT_RST   7'h00
`define CLEAN_CNT_MAX   7'h7F
`endif

//--- common/isa_guard_pkg.sv
// types for the instruction-set transition guard
package isa_guard_pkg;
  typedef enum logic [0:0]
  {
    ISA_NATIVE = 1'b0,
    ISA_LEGACY = 1'b1
  } isa_mode_t;
  typedef enum logic [1:0]
  {
    OP_NONE = 2'b00,
    OP_FP   = 2'b01,
    OP_VEC  = 2'b10,
    OP_INT  = 2'b11
  } legacy_op_t;
endpackage

//--- common/fp_operand_if.sv
// operand path between guard top and fp operand filter
`timescale 1ns/10ps
interface fp_operand_if;
  logic [81:0] raw_reg;
  logic [1:0]  op_kind;
  logic        fault_val;
  logic [81:0] filtered;
  logic [63:0] mant_data;
  modport top (output raw_reg, output op_kind, input fault_val, input filtered,
               input mant_data);
  modport filt (input raw_reg, input op_kind, output fault_val, output filtered,
                output mant_data);
endinterface

//--- rtl/fp_operand_filter.sv
// classifies a floating-point register operand for legacy consumers
`timescale 1ns/10ps
`include "isa_guard_consts.svh"
module fp_operand_filter
  import isa_guard_pkg::*;
(
  fp_operand_if.filt op
);
  logic is_fault;

  always_comb
  begin
    is_fault = (op.raw_reg[`FP_EXP_MSB:`FP_EXP_LSB] == `FAULT_VAL_EXP)
             && (op.raw_reg[`FP_SIGN_BIT] == `FAULT_VAL_SIGN)
             && (op.raw_reg[`FP_MANT_W-1:0] == `FAULT_VAL_MANT);
    op.fault_val = is_fault;
    op.mant_data = op.raw_reg[`FP_MANT_W-1:0];
    op.filtered  = op.raw_reg;
    if (is_fault && (legacy_op_t'(op.op_kind) == OP_FP))
    begin
      op.filtered = {`FAULT_VAL_SIGN, `SNAN_EXP, `SNAN_MANT};
    end
  end
endmodule

//--- tb/isa_guard_props.sv
// property checker for the isa transition guard
`timescale 1ns/10ps
module isa_guard_props (
  input wire logic        sys_clk_i,
  input wire logic        sys_rst_i,
  input wire logic        legacy_entry_branch_i,
  input wire logic        legacy_exit_jump_i,
  input wire logic        interruption_i,
  input wire logic        marker_present_i,
  input wire logic [1:0]  legacy_op_i,
  input wire logic [81:0] fp_src_i,
  input wire logic        fp_src_from_mem_i,
  input wire logic        legacy_mode_o,
  input wire logic        register_stack_engine_en_o,
  input wire logic        stacked_valid_o,
  input wire logic [6:0]  clean_count_o,
  input wire logic        advanced_load_table_valid_o,
  input wire logic        deferred_fault_marker_abort_o,
  input wire logic        legacy_fp_error_o,
  input wire logic [81:0] fp_result_o,
  input wire logic [63:0] vec_data_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);
  wire lx = legacy_exit_jump_i || interruption_i;
  wire go = legacy_mode_o && !lx && !marker_present_i;
  wire nv = fp_src_i == 82'h1FFFE0000000000000000;
  wire [63:0] mn = fp_src_i[63:0];
  ////////////////////////////////////////////////////////////////////////////
  a_rse_held_off: assert property (legacy_mode_o |-> !register_stack_engine_en_o)
    else $error("stack engine on in legacy mode");
  a_entry_hides_table: assert property (
    !legacy_mode_o && legacy_entry_branch_i && !interruption_i |=> legacy_mode_o
    && !advanced_load_table_valid_o && !register_stack_engine_en_o)
    else $error("entry side effects missing");
  a_exit_clears_stack: assert property (
    legacy_mode_o && lx |=> !legacy_mode_o && !stacked_valid_o && clean_count_o == 7'h00)
    else $error("exit side effects missing");
  a_abort_on_marker: assert property (
    legacy_mode_o && !lx && marker_present_i && legacy_op_i != 2'h0
    |=> deferred_fault_marker_abort_o && $stable(vec_data_o))
    else $error("no abort on marked operand");
  a_fp_never_silent: assert property (
    go && legacy_op_i == 2'h1 && nv && !fp_src_from_mem_i |=> legacy_fp_error_o)
    else $error("deferred value used silently");
  a_snan_convert: assert property (
    go && legacy_op_i == 2'h1 && nv && !fp_src_from_mem_i
    |=> fp_result_o == 82'h1FFFF8000000000000001)
    else $error("no signalling nan result");
  a_vec_mantissa: assert property (
    go && legacy_op_i[1] |=> vec_data_o == $past(mn))
    else $error("vector data not the mantissa");
  a_mem_no_deferred_fault_fp_value: assert property (
    go && legacy_op_i == 2'h1 && fp_src_from_mem_i |=> !legacy_fp_error_o)
    else $error("memory operand faulted");
endmodule
bind isa_transition_state_guard isa_guard_props u_props (.sys_clk_i(sys_clk_i),
  .sys_rst_i(sys_rst_i), .legacy_entry_branch_i(legacy_entry_branch_i),
  .legacy_exit_jump_i(legacy_exit_jump_i), .interruption_i(interruption_i),
  .marker_present_i(marker_present_i), .legacy_op_i(legacy_op_i), .fp_src_i(fp_src_i),
  .fp_src_from_mem_i(fp_src_from_mem_i), .legacy_mode_o(legacy_mode_o),
  .register_stack_engine_en_o(register_stack_engine_en_o), .stacked_valid_o(stacked_valid_o),
  .clean_count_o(clean_count_o), .advanced_load_table_valid_o(advanced_load_table_valid_o),
  .deferred_fault_marker_abort_o(deferred_fault_marker_abort_o),
  .legacy_fp_error_o(legacy_fp_error_o), .fp_result_o(fp_result_o), .vec_data_o(vec_data_o));

//--- tb/tb_top.sv
// self-checking bench for the isa transition guard
`timescale 1ns/10ps
module tb_top;
  logic clk = 0, rst = 1, en = 0, ex = 0, irq = 0, eng = 1, sv = 0, ci = 0, al = 0;
  logic mk = 0, mem = 0, md, re, so, av, ab, fe, np;
  logic [1:0]  op = 0;
  logic [81:0] src = 0, fr;
  logic [6:0]  cc;
  logic [63:0] vd;
  int          fail_count = 0, tests_run = 0;
  always #4 clk = ~clk;
  isa_transition_state_guard dut (.sys_clk_i(clk), .sys_rst_i(rst), .legacy_entry_branch_i(en),
    .legacy_exit_jump_i(ex), .interruption_i(irq), .register_stack_engine_ctrl_en_i(eng),
    .stacked_valid_set_i(sv), .clean_inc_i(ci), .advanced_load_table_insert_i(al),
    .marker_present_i(mk), .legacy_op_i(op), .fp_src_i(src), .fp_src_from_mem_i(mem),
    .legacy_mode_o(md), .register_stack_engine_en_o(re), .stacked_valid_o(so),
    .clean_count_o(cc), .advanced_load_table_valid_o(av), .deferred_fault_marker_abort_o(ab),
    .legacy_fp_error_o(fe), .deferred_fault_fp_value_prop_o(np), .fp_result_o(fr),
    .vec_data_o(vd));
  ////////////////////////////////////////////////////////////////////////////
  task chk(input logic [81:0] g, input logic [81:0] e);
    tests_run++;
    if (g !== e)
    begin
      fail_count++;
      $display("wrong value at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task tick;
    @(negedge clk);
  endtask
  // refused exit in native mode, then stack and table state built up
  task t_native;
    tick;
    ex = 1;
    op = 1;
    tick;
    ex = 0;
    op = 0;
    chk(md, 0);
    sv = 1;
    al = 1;
    ci = 1;
    tick;
    tick;
    sv = 0;
    al = 0;
    ci = 0;
    chk(cc, 2);
    chk(so, 1);
    chk(av, 1);
    chk(re, 1);
    eng = 0;
    tick;
    chk(re, 0);
    eng = 1;
    tick;
    chk(re, 1);
  endtask
  // no marker in legacy state, stack state built by t_native not flushed
  task t_entry;
    mk = 0;
    en = 1;
    tick;
    en = 0;
    chk(md, 1);
    chk(re, 0);
    chk(av, 0);
  endtask
  task t_fp;
    src = 82'h1FFFE0000000000000000;
    op = 1;
    tick;
    chk(fe, 1);
    chk(np, 0);
    chk(fr, 82'h1FFFF8000000000000001);
    mem = 1;
    tick;
    mem = 0;
    op = 0;
    chk(fe, 0);
  endtask
  task t_vec;
    tick;
    src = 82'h3FFFE0123456789ABCDEF;
    op = 2;
    tick;
    chk(vd, 64'h0123456789ABCDEF);
    src = 82'h1FFFE0000000000000000;
    tick;
    chk(vd, 64'h0);
    chk(fe, 0);
    src = 82'h2ABCDFEDCBA9876543210;
    op = 3;
    tick;
    op = 0;
    chk(vd, 64'hFEDCBA9876543210);
  endtask
  task t_abort;
    tick;
    mk = 1;
    op = 1;
    tick;
    chk(ab, 1);
    chk(fr, 82'h1FFFE0000000000000000);
    src = 82'h0;
    op = 3;
    tick;
    chk(ab, 1);
    chk(vd, 64'hFEDCBA9876543210);
    mk = 0;
    op = 0;
  endtask
  task t_exit(input bit by_irq);
    ex = !by_irq;
    irq = by_irq;
    tick;
    ex = 0;
    irq = 0;
    chk(md, 0);
    chk(so, 0);
    chk(cc, 0);
    chk(re, 1);
  endtask
  task results;
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (16) @(posedge clk);
    tick;
    rst = 0;
    tick;
    t_native;
    t_entry;
    t_fp;
    t_vec;
    t_abort;
    t_exit(0);
    t_native;
    t_entry;
    t_exit(1);
    results;
  end
  initial
  begin
    #2000;
    fail_count++;
    results;
  end
endmodule
